// ---- iaf_core.sv ----
// Pointer unit with indirect data RAM access and arithmetic flag register.
// Assumes a synchronous RAM that returns read data the cycle after en.
//
// Behaviour
// - Three 12-bit pointers from two bytes.
// - Virtual operand accesses RAM at pointer address.
// - Indirect read of virtual location returns zero, sets Z.
// - Indirect write of virtual location is a no-op.
// - Five access locations select five pointer behaviours.
// - Pointer stepping leaves all flags alone.
// - Stepping carries and borrows across all 12 bits.
// - Indexed address is pointer plus signed accumulator.
// - Write to pointer byte beats auto stepping.
// - Flag-affecting result overrides writes to flag bits.
// - Flag bits 7 to 5 read zero.
// - Negative flag follows result bit 7.
// - Overflow flag marks signed wrap.
// - Zero flag marks a zero result.
// - Half carry from bit 3, rotates load bit.
// - Carry from bit 7, rotates load end bit.
// - Subtract adds two's complement; carry means no borrow.
//
// The APB register port and the register addresses were decided locally.
module iaf_core
    import iaf_pkg::*;
(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    // Data RAM
    output iaf_ram_req_t      ram_req,
    input  wire logic [7:0]   ram_rdata
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum {ST_IDLE, ST_REQ, ST_CAPT} iaf_st_t;

    iaf_st_t          st;
    iaf_st_t          next_st;
    logic [11:0]      ptr [NPTR];
    logic [11:0]      next_ptr [NPTR];
    logic [7:0]       acc;
    logic [7:0]       next_acc;
    logic [7:0]       flg;
    logic [7:0]       next_flg;
    logic [31:0]      next_prdata;
    logic             next_pready;
    logic             next_pslverr;
    iaf_ram_req_t     next_ram;

    logic             take;
    logic [4:0]       idx;
    logic [1:0]       n;
    logic [2:0]       k;
    logic             is_op;
    logic             mapped;
    logic [11:0]      sx;
    logic [11:0]      eff;
    logic [11:0]      base;
    logic             tvirt;
    logic             tint;
    logic             ram_go;
    logic [7:0]       alu_b;
    logic             wr_en;
    logic [4:0]       wr_idx;
    logic [7:0]       wr_dat;
    iaf_alu_t         r;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic is_ptr_loc(input logic [4:0] i, input logic [2:0] lim);
        return (i[4:3] < 2'd3) && (i[2:0] < lim);
    endfunction

    function automatic logic [7:0] reg_read(input logic [4:0] i);
        logic [7:0] v;
        v = 8'h00;
        if (i == IDX_ACC) begin
            v = acc;
        end else if (i == IDX_FLG) begin
            v = flg & FLG_MASK;
        end else if (is_ptr_loc(i, 3'd7) && i[2:0] == K_LO) begin
            v = ptr[i[4:3]][7:0];
        end else if (is_ptr_loc(i, 3'd7) && i[2:0] == K_HI) begin
            v = {4'h0, ptr[i[4:3]][11:8]};
        end
        return v;
    endfunction

    function automatic iaf_alu_t alu_calc(input iaf_op_t op, input logic [7:0] a,
                                          input logic [7:0] b, input logic c);
        iaf_alu_t   q;
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] h;
        bb = (op == OP_SUB) ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + 9'(op == OP_SUB);
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(op == OP_SUB);
        q.res = s[7:0];
        q.flg = 8'h00;
        q.msk = 8'h00;
        case (op)
            OP_ADD, OP_SUB: begin
                q.flg[FB_C]  = s[8];
                q.flg[FB_DC] = h[4];
                q.flg[FB_OV] = (a[7] == bb[7]) && (s[7] != a[7]);
                q.msk = MSK_ARITH;
            end
            OP_AND: begin
                q.res = a & b;
                q.msk = MSK_LOGIC;
            end
            OP_RLC: begin
                q.res = {b[6:0], c};
                q.flg[FB_C]  = b[7];
                q.flg[FB_DC] = b[3];
                q.msk = MSK_ROT;
            end
            OP_RRC: begin
                q.res = {c, b[7:1]};
                q.flg[FB_C]  = b[0];
                q.flg[FB_DC] = b[4];
                q.msk = MSK_ROT;
            end
            default: begin
                q.res = b;
            end
        endcase
        q.flg[FB_N] = q.res[7];
        q.flg[FB_Z] = (q.res == 8'h00);
        return q;
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign take   = psel && penable && !pready && st == ST_IDLE;
    assign idx    = paddr[6:2];
    assign n      = idx[4:3];
    assign k      = idx[2:0];
    assign is_op  = is_ptr_loc(idx, 3'd5);
    assign mapped = paddr[11:7] == 5'h00 && paddr[1:0] == 2'b00
                    && (is_ptr_loc(idx, 3'd7) || (idx >= IDX_ACC && idx <= IDX_ALU));
    assign sx     = {{4{acc[7]}}, acc};
    assign base   = ptr[n < 2'd3 ? n : 2'd0];
    assign alu_b  = pwdata[7:0];
    assign r      = alu_calc(iaf_op_t'(pwdata[CMD_OP_LSB+:3]), acc, alu_b, flg[FB_C]);

    // Access address: pre-increment and indexing form it before the access.
    always_comb begin
        case (k)
            K_PRE:   eff = base + 12'h001;
            K_IDX:   eff = base + sx;
            default: eff = base;
        endcase
    end

    // Targets at pointer, accumulator or flag locations inside the pointer window never reach the RAM.
    assign tvirt  = eff[11:5] == WIN_HI && is_ptr_loc(eff[4:0], 3'd5);
    assign tint   = eff[11:5] == WIN_HI && (is_ptr_loc(eff[4:0], 3'd7)
                    || eff[4:0] == IDX_ACC || eff[4:0] == IDX_FLG);
    assign ram_go = take && mapped && is_op && !tint;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st      = st;
        next_ptr     = ptr;
        next_acc     = acc;
        next_flg     = flg;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        next_ram     = ram_req;
        next_ram.en  = 1'b0;
        wr_en        = 1'b0;
        wr_idx       = idx;
        wr_dat       = pwdata[7:0];
        case (st)
            ST_IDLE: begin
                if (take) begin
                    next_pready = 1'b1;
                    next_prdata = 32'h0;
                    if (!mapped) begin
                        next_pslverr = 1'b1;
                    end else if (is_op) begin
                        // Stepping touches the pointer only, never flags.
                        case (k)
                            K_PDEC: next_ptr[n] = ptr[n] - 12'h001;
                            K_PINC: next_ptr[n] = ptr[n] + 12'h001;
                            K_PRE:  next_ptr[n] = eff;
                            default: next_ptr[n] = ptr[n];
                        endcase
                        if (tvirt) begin
                            if (!pwrite) begin
                                next_flg[FB_Z] = 1'b1;
                            end
                        end else if (tint) begin
                            wr_en  = pwrite;
                            wr_idx = eff[4:0];
                            if (!pwrite) begin
                                next_prdata = {24'h0, reg_read(eff[4:0])};
                            end
                        end else begin
                            next_pready = 1'b0;
                            next_st     = ST_REQ;
                            next_ram    = '{1'b1, pwrite, eff, pwdata[7:0]};
                        end
                    end else if (idx == IDX_ALU) begin
                        if (!pwrite) begin
                            next_prdata = 32'h0;
                        end else if (pwdata[CMD_DST]) begin
                            // Affected flag bits follow the result, not the data.
                            next_flg = ((r.res & ~r.msk) | (r.flg & r.msk)) & FLG_MASK;
                        end else begin
                            next_acc = r.res;
                            next_flg = (flg & ~r.msk) | (r.flg & r.msk);
                        end
                    end else if (pwrite) begin
                        wr_en = 1'b1;
                    end else begin
                        next_prdata = {24'h0, reg_read(idx)};
                    end
                end
            end
            ST_REQ: begin
                next_st = ST_CAPT;
            end
            ST_CAPT: begin
                next_st     = ST_IDLE;
                next_pready = 1'b1;
                if (!ram_req.we) begin
                    next_prdata = {24'h0, ram_rdata};
                end
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
        // A byte write rebuilds its pointer from the old value, so no step survives it.
        if (wr_en) begin
            if (wr_idx == IDX_ACC) begin
                next_acc = wr_dat;
            end else if (wr_idx == IDX_FLG) begin
                next_flg = wr_dat & FLG_MASK;
            end else if (wr_idx[2:0] == K_LO) begin
                next_ptr[wr_idx[4:3]] = {ptr[wr_idx[4:3]][11:8], wr_dat};
            end else if (wr_idx[2:0] == K_HI) begin
                next_ptr[wr_idx[4:3]] = {wr_dat[3:0], ptr[wr_idx[4:3]][7:0]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st      <= ST_IDLE;
            ptr     <= '{default: PTR_RST};
            acc     <= ACC_RST;
            flg     <= FLG_RST;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            ram_req <= '0;
        end else begin
            st      <= next_st;
            ptr     <= next_ptr;
            acc     <= next_acc;
            flg     <= next_flg;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            ram_req <= next_ram;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_RSV: assert property (flg[7:5] == 3'h0)
        else $error("flag upper bits not zero");
    AST_PINC: assert property (ram_go && n == 2'd0 && k == K_PINC
        |=> ptr[0] == $past(ptr[0]) + 12'h001 && $stable(flg))
        else $error("post-increment wrong");
    AST_PDEC: assert property (ram_go && n == 2'd0 && k == K_PDEC
        |=> ptr[0] == $past(ptr[0]) - 12'h001 && $stable(flg))
        else $error("post-decrement wrong or flags moved");
    AST_PRE: assert property (ram_go && n == 2'd0 && k == K_PRE
        |=> ram_req.addr == ptr[0] && ptr[0] == $past(ptr[0]) + 12'h001)
        else $error("pre-increment address wrong");
    AST_IDX: assert property (ram_go && n == 2'd0 && k == K_IDX
        |=> $stable(ptr[0]) && $stable(acc) && ram_req.addr == $past(ptr[0]) + $past(sx))
        else $error("indexed address wrong");
    AST_VRD: assert property (take && mapped && is_op && tvirt && !pwrite
        |=> pready && prdata == 32'h0 && flg[FB_Z])
        else $error("virtual read not zero");
    AST_VWR: assert property (take && mapped && is_op && tvirt && pwrite
        |=> !ram_req.en && $stable(flg) && $stable(acc))
        else $error("virtual write not a no-op");
    AST_RAM: assert property (ram_go
        |=> ram_req.en && !pready ##1 !ram_req.en && !pready ##1 pready)
        else $error("RAM access timing wrong");
    AST_DOM: assert property (take && mapped && n == 2'd0 && k == K_PINC && pwrite
        && tint && eff[4:0] == 5'h05 |=> ptr[0][7:0] == $past(wr_dat))
        else $error("byte write lost to stepping");
    AST_SUBC: assert property (take && idx == IDX_ALU && pwrite
        && pwdata[10:8] == 3'(OP_SUB) && !pwdata[CMD_DST]
        |=> flg[FB_C] == ($past(acc) >= $past(alu_b)))
        else $error("subtract carry wrong");

    COV_PINC: cover property (ram_go && k == K_PINC ##3 pready);
    COV_VRD:  cover property (take && tvirt && is_op && !pwrite);
    COV_ROT:  cover property (take && idx == IDX_ALU && pwrite && pwdata[10:8] == 3'(OP_RLC));
    COV_DST:  cover property (take && idx == IDX_ALU && pwrite && pwdata[CMD_DST]);
endmodule

// ---- iaf_pkg.sv ----
// Constants, types and register layout for the indirect pointer unit.
// Assumes a single core clock and an APB master with 12-bit byte addresses.
package iaf_pkg;
    // ------------------------------------------------------------
    // Pointer and data space
    // ------------------------------------------------------------
    localparam int          PTR_W   = 12;
    localparam int          NPTR    = 3;
    localparam logic [6:0]  WIN_HI  = 7'h7f;
    localparam logic [11:0] PTR_RST = 12'h000;
    localparam logic [7:0]  ACC_RST = 8'h00;
    localparam logic [7:0]  FLG_RST = 8'h00;
    // ------------------------------------------------------------
    // Location kinds within one pointer's group of eight
    // ------------------------------------------------------------
    localparam logic [2:0]  K_PLAIN = 3'h0;
    localparam logic [2:0]  K_PDEC  = 3'h1;
    localparam logic [2:0]  K_PINC  = 3'h2;
    localparam logic [2:0]  K_PRE   = 3'h3;
    localparam logic [2:0]  K_IDX   = 3'h4;
    localparam logic [2:0]  K_LO    = 3'h5;
    localparam logic [2:0]  K_HI    = 3'h6;
    localparam logic [4:0]  IDX_ACC = 5'h18;
    localparam logic [4:0]  IDX_FLG = 5'h19;
    localparam logic [4:0]  IDX_ALU = 5'h1a;
    // ------------------------------------------------------------
    // Flag bits and masks
    // ------------------------------------------------------------
    localparam int          FB_C      = 0;
    localparam int          FB_DC     = 1;
    localparam int          FB_Z      = 2;
    localparam int          FB_OV     = 3;
    localparam int          FB_N      = 4;
    localparam logic [7:0]  FLG_MASK  = 8'h1f;
    localparam logic [7:0]  MSK_ARITH = 8'h1f;
    localparam logic [7:0]  MSK_LOGIC = 8'h14;
    localparam logic [7:0]  MSK_ROT   = 8'h17;
    // ------------------------------------------------------------
    // Arithmetic command word layout
    // ------------------------------------------------------------
    localparam int          CMD_OP_LSB = 8;
    localparam int          CMD_DST    = 11;

    typedef enum logic [2:0] {OP_ADD, OP_SUB, OP_AND, OP_RLC, OP_RRC, OP_MOV} iaf_op_t;

    typedef struct packed {
        logic        en;
        logic        we;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } iaf_ram_req_t;

    typedef struct packed {
        logic [7:0] res;
        logic [7:0] flg;
        logic [7:0] msk;
    } iaf_alu_t;
endpackage

// ---- iaf_ram_model.sv ----
// Behavioural data RAM on the far side of the pointer unit.
// Assumes one request at a time; read data is valid the cycle after en.
module iaf_ram_model
    import iaf_pkg::*;
(
    // Clock
    input  wire logic          pclk,
    // Request and answer
    input  wire iaf_ram_req_t  ram_req,
    output logic [7:0]         ram_rdata
);
    // ------------------------------------------------------------
    // Storage and read port
    // ------------------------------------------------------------
    logic [7:0] mem [4096];
    logic [7:0] q;
    logic       vld = 1'b0;

    always @(posedge pclk) begin
        vld <= ram_req.en;
        if (ram_req.en) begin
            if (ram_req.we) begin
                mem[ram_req.addr] <= ram_req.wdata;
            end
            q <= mem[ram_req.addr];
        end
    end

    // Outside the valid cycle the data is inverted, so a late sample shows up.
    assign ram_rdata = vld ? q : ~q;
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the pointer unit and its flag register.
// Assumes the RAM model as partner and an APB master driven here.
module tb_top
    import iaf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Signals, cases and instances
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  pre;
        logic [7:0]  acc;
        logic [11:0] cmd;
        logic [7:0]  eacc;
        logic [7:0]  eflg;
    } iaf_case_t;
    localparam iaf_case_t CASES [11] = '{
        '{8'h00, 8'h7f, 12'h001, 8'h80, 8'h1a}, '{8'h00, 8'hff, 12'h001, 8'h00, 8'h07},
        '{8'h00, 8'h05, 12'h105, 8'h00, 8'h07}, '{8'h00, 8'h00, 12'h101, 8'hff, 8'h10},
        '{8'h04, 8'h80, 12'h101, 8'h7f, 8'h09}, '{8'h0b, 8'hf0, 12'h20f, 8'h00, 8'h0f},
        '{8'h00, 8'h00, 12'h381, 8'h02, 8'h01}, '{8'h01, 8'h00, 12'h418, 8'h8c, 8'h12},
        '{8'h0b, 8'h55, 12'h500, 8'h00, 8'h0b}, '{8'h00, 8'hff, 12'h801, 8'hff, 8'h07},
        '{8'h00, 8'h1f, 12'ha13, 8'h1f, 8'h03}};
    logic         pclk;
    logic         presetn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [11:0]  paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    iaf_ram_req_t ram_req;
    logic [7:0]   ram_rdata;
    int           err_total;
    int           compares;
    int           en_cnt = 0;

    iaf_core i_iaf_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ram_req(ram_req), .ram_rdata(ram_rdata));
    iaf_ram_model i_iaf_ram_model (.pclk(pclk), .ram_req(ram_req), .ram_rdata(ram_rdata));

    always #2.5 pclk = ~pclk;
    always @(posedge pclk) if (ram_req.en === 1'b1) en_cnt++;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [11:0] ba(input logic [4:0] idx);
        return {5'h00, idx, 2'h0};
    endfunction
    function automatic logic [11:0] ia(input logic [1:0] n, input logic [2:0] k);
        return ba({n, k});
    endfunction
    task automatic results();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // The request is held until pready is sampled high; the wait is bounded.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 40) chk(0, 1);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        chk(e, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk({e, q[31:8]}, 0);
        d = q[7:0];
    endtask
    task automatic set_ptr(input logic [1:0] n, input logic [11:0] v);
        wr(ia(n, K_LO), v[7:0]);
        wr(ia(n, K_HI), v[11:8]);
    endtask
    task automatic chk_ptr(input logic [1:0] n, input logic [11:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(ia(n, K_LO), lo);
        rd(ia(n, K_HI), hi);
        chk({hi, lo}, v);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] d;
        rd(ba(IDX_ACC), d);
        chk(d, ACC_RST);
        rd(ba(IDX_FLG), d);
        chk(d, FLG_RST);
        for (int n = 0; n < 3; n++) chk_ptr(n[1:0], PTR_RST);
    endtask
    task automatic t_modes();
        logic [7:0] d;
        for (logic [1:0] n = 0; n < 3; n++) begin
            wr(ba(IDX_FLG), 8'h00);
            set_ptr(n, 12'h0ff);
            wr(ia(n, K_PINC), 8'h5a);
            chk(i_iaf_ram_model.mem[12'h0ff], 8'h5a);
            chk_ptr(n, 12'h100);
            wr(ia(n, K_PRE), 8'ha5);
            chk(i_iaf_ram_model.mem[12'h101], 8'ha5);
            rd(ia(n, K_PDEC), d);
            chk(d, 8'ha5);
            wr(ia(n, K_PDEC), 8'h3c);
            chk(i_iaf_ram_model.mem[12'h100], 8'h3c);
            chk_ptr(n, 12'h0ff);
            rd(ia(n, K_PLAIN), d);
            chk(d, 8'h5a);
            set_ptr(n, 12'h000);
            wr(ia(n, K_PDEC), 8'h11);
            chk_ptr(n, 12'hfff);
            wr(ia(n, K_PRE), 8'h22);
            chk(i_iaf_ram_model.mem[12'h000], 8'h22);
            rd(ba(IDX_FLG), d);
            chk(d, 8'h00);
        end
    endtask
    task automatic t_index();
        logic [7:0] a [2] = '{8'hfe, 8'h05};
        logic [7:0] d;
        for (int i = 0; i < 2; i++) begin
            set_ptr(2'h1, 12'h200);
            wr(ba(IDX_ACC), a[i]);
            wr(ia(2'h1, K_IDX), 8'h30 + i);
            chk(i_iaf_ram_model.mem[12'h200 + {{4{a[i][7]}}, a[i]}], 8'h30 + i);
            chk_ptr(2'h1, 12'h200);
            rd(ba(IDX_ACC), d);
            chk(d, a[i]);
        end
    endtask
    task automatic t_virtual();
        logic [7:0] d;
        int         c0;
        set_ptr(2'h2, 12'hfe0);
        wr(ba(IDX_FLG), 8'h0b);
        c0 = en_cnt;
        wr(ia(2'h2, K_PLAIN), 8'h77);
        rd(ba(IDX_FLG), d);
        chk(d, 8'h0b);
        rd(ia(2'h2, K_PLAIN), d);
        chk(d, 8'h00);
        rd(ba(IDX_FLG), d);
        chk(d, 8'h0f);
        chk(en_cnt, c0);
    endtask
    task automatic t_ptr_dom();
        set_ptr(2'h0, 12'hfe5);
        wr(ia(2'h0, K_PINC), 8'h40);
        chk_ptr(2'h0, 12'hf40);
        set_ptr(2'h0, 12'hfe6);
        wr(ia(2'h0, K_PDEC), 8'h03);
        chk_ptr(2'h0, 12'h3e6);
    endtask
    task automatic t_alu();
        logic [7:0] d;
        foreach (CASES[i]) begin
            wr(ba(IDX_FLG), CASES[i].pre);
            wr(ba(IDX_ACC), CASES[i].acc);
            wr(ba(IDX_ALU), CASES[i].cmd);
            rd(ba(IDX_ACC), d);
            chk(d, CASES[i].eacc);
            rd(ba(IDX_FLG), d);
            chk(d, CASES[i].eflg);
        end
        wr(ba(IDX_FLG), 8'hff);
        rd(ba(IDX_FLG), d);
        chk(d, 8'h1f);
    endtask
    task automatic t_unmapped();
        logic [11:0] a [4] = '{12'h080, 12'h002, ba(5'h1b), ba(5'h07)};
        logic [31:0] q;
        logic        e;
        foreach (a[i]) begin
            apb(1'b0, a[i], 32'h0, q, e);
            chk(e, 1'b1);
        end
    endtask
    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        err_total = 0; compares = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_modes();
        t_index();
        t_virtual();
        t_ptr_dom();
        t_alu();
        t_unmapped();
        results();
    end
    // About 160 transfers of a few cycles each fit well inside this span.
    initial begin
        #200000;
        err_total++;
        results();
    end
endmodule
